// [core/tmz_timer.sv]
/*
  tmz_timer: 8-bit timer/counter with a prescaler shared with the
  watchdog, external pin or comparator source, edge select, write
  inhibit and phase sampling of the external count level.
  Assumes the watchdog supplies its raw tick and clear pulses on mclk,
  the comparator output and the external pin arrive asynchronously,
  and the register port is a plain strobe port with no wait states.
*/
`timescale 1ns/100ps
module tmz_timer
  import tmz_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdata,
  input wire logic timerExtClkPinIn,
  output logic timerExtClkPinOut,
  output logic timerExtClkPinOe,
  input wire logic comparatorOut,
  input wire logic gpioPinLevel,
  input wire logic gpioPinDrive,
  input wire logic watchdogTick,
  input wire logic watchdogClearInstr,
  output logic watchdogTickOut,
  output logic [DATA_W-1:0] timerCount
);

  // ------------------------------------------------------------
  // bus request bundle
  // ------------------------------------------------------------
  tmz_bus_req_t busReq;
  assign busReq.addr = regAddr;
  assign busReq.wdata = regWdata;
  assign busReq.wr = regWr;
  assign busReq.rd = regRd;

  // ------------------------------------------------------------
  // software visible registers
  // ------------------------------------------------------------
  logic [DATA_W-1:0] option_r;
  logic [DATA_W-1:0] cmpCtrl_r;
  logic [DATA_W-1:0] timerCount_r;
  logic [DATA_W-1:0] timerCount_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  // address decode
  wire hitOption = busReq.addr == OFS_OPTION;
  wire hitCount = busReq.addr == OFS_COUNT;
  wire hitCmpCtrl = busReq.addr == OFS_CMPCTRL;
  wire wrOption = busReq.wr & hitOption;
  wire wrCount = busReq.wr & hitCount;
  wire wrCmpCtrl = busReq.wr & hitCmpCtrl;

  // configuration fields
  wire srcSel = option_r[OPT_SRC_SEL];
  wire edgeSel = option_r[OPT_EDGE_SEL];
  wire toWatchdog = option_r[OPT_ASSIGN];
  wire toTimer = ~toWatchdog;
  wire [RATIO_W-1:0] ratio = option_r[OPT_RATIO_LO +: RATIO_W];
  wire cmpSrcN = cmpCtrl_r[CMP_SRC_N];
  wire pinOutDis = cmpCtrl_r[CMP_PIN_OUT_DIS];

  // ------------------------------------------------------------
  // instruction phase generator
  // ------------------------------------------------------------
  logic [PHASE_W-1:0] qPhase_r;
  wire q2En = qPhase_r == PH_Q2;
  wire q4En = qPhase_r == PH_Q4;
  wire cycleEnd = q4En;

  // phase counter wraps Q1..Q4
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      qPhase_r <= PH_Q1;
    end else begin
      qPhase_r <= qPhase_r + 2'h1;
    end
  end

  // ------------------------------------------------------------
  // asynchronous inputs into the mclk domain
  // ------------------------------------------------------------
  logic [1:0] syncIn;
  tmz_sync2 #(
    .WIDTH(2)
  ) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .asyncIn({comparatorOut, timerExtClkPinIn}),
    .syncOut(syncIn)
  );
  wire pinSync = syncIn[0];
  wire cmpSync = syncIn[1];

  // ------------------------------------------------------------
  // count source and edge selection
  // ------------------------------------------------------------
  // pin input path stays live even while comparator drives the pin
  wire srcLevel = cmpSrcN ? pinSync : cmpSync;
  // inverting turns falling edges into rising ones
  wire edgeLevel = srcLevel ^ edgeSel;
  logic edgePrev_r;
  wire srcRise = edgeLevel & ~edgePrev_r;

  // previous level for edge detection
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      edgePrev_r <= RST_OPTION[OPT_EDGE_SEL]; // idle level, no false edge
    end else begin
      edgePrev_r <= edgeLevel;
    end
  end

  // ------------------------------------------------------------
  // shared prescaler
  // ------------------------------------------------------------
  // in timer mode the prescaler eats cycles, in counter mode edges
  wire timerTick = srcSel ? srcRise : cycleEnd;
  wire prescEn = toTimer ? timerTick : watchdogTick;
  wire prescClr = (toTimer & wrCount) | (toWatchdog & watchdogClearInstr);
  logic prescTap;
  logic prescRise;

  tmz_prescaler u_presc (
    .mclk(mclk),
    .reset_n(reset_n),
    .countEn(prescEn),
    .clear(prescClr),
    .ratio(ratio),
    .tapLevel(prescTap),
    .tapRise(prescRise)
  );

  // ------------------------------------------------------------
  // phase sampling of the prescaler output
  // ------------------------------------------------------------
  // without prescaler the output equals the selected external level
  wire sampLevel = toTimer ? prescTap : edgeLevel;
  wire sampEn = q2En | q4En;
  logic sampled_r;
  wire sampRise = sampEn & sampLevel & ~sampled_r;

  // sampled level, refreshed on Q2 and Q4 only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sampled_r <= RST_OPTION[OPT_EDGE_SEL]; // idle level, no false rise
    end else if (sampEn) begin
      sampled_r <= sampLevel;
    end
  end

  // ------------------------------------------------------------
  // increment inhibit after a count write
  // ------------------------------------------------------------
  logic [INHIBIT_W-1:0] inhibit_r;
  logic [INHIBIT_W-1:0] inhibit_nxt;
  wire inhibited = inhibit_r != INHIBIT_NONE;

  // load on write, step down at each cycle end
  always_comb begin
    inhibit_nxt = inhibit_r;
    if (wrCount) begin
      inhibit_nxt = INHIBIT_CYCLES;
    end else if (cycleEnd && inhibited) begin
      inhibit_nxt = inhibit_r - INHIBIT_STEP;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      inhibit_r <= INHIBIT_NONE;
    end else begin
      inhibit_r <= inhibit_nxt;
    end
  end

  // ------------------------------------------------------------
  // count register
  // ------------------------------------------------------------
  // timer mode: each cycle, or each prescaler tap rise
  wire timerModeInc = toTimer ? prescRise : cycleEnd;
  // counter mode: rise of the phase-sampled level
  wire counterModeInc = sampRise;
  wire incReq = srcSel ? counterModeInc : timerModeInc;
  wire incTimer = incReq & ~inhibited;

  // software write beats an increment in the same cycle
  always_comb begin
    timerCount_nxt = timerCount_r;
    if (wrCount) begin
      timerCount_nxt = busReq.wdata;
    end else if (incTimer) begin
      timerCount_nxt = timerCount_r + COUNT_STEP;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      timerCount_r <= RST_COUNT;
    end else begin
      timerCount_r <= timerCount_nxt;
    end
  end
  assign timerCount = timerCount_r;

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      option_r <= RST_OPTION;
    end else if (wrOption) begin
      option_r <= busReq.wdata;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cmpCtrl_r <= RST_CMPCTRL;
    end else if (wrCmpCtrl) begin
      cmpCtrl_r <= busReq.wdata;
    end
  end

  // ------------------------------------------------------------
  // read port, data one cycle after the strobe
  // ------------------------------------------------------------
  // prescaler has no address and never reads back
  always_comb begin
    rdata_nxt = READ_ZERO;
    if (busReq.rd) begin
      if (hitOption) begin
        rdata_nxt = option_r;
      end else if (hitCount) begin
        rdata_nxt = timerCount_r;
      end else if (hitCmpCtrl) begin
        rdata_nxt = cmpCtrl_r;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= READ_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign regRdata = rdata_r;

  // ------------------------------------------------------------
  // external clock pin direction and level
  // ------------------------------------------------------------
  tmz_pin_drv_t pinDrv_nxt;
  tmz_pin_drv_t pinDrv_r;

  // source select takes the pin away from the port logic
  always_comb begin
    pinDrv_nxt.drive = gpioPinDrive;
    pinDrv_nxt.level = gpioPinLevel;
    if (srcSel) begin
      pinDrv_nxt.drive = cmpSrcN & ~pinOutDis;
      pinDrv_nxt.level = cmpSync;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pinDrv_r <= '0;
    end else begin
      pinDrv_r <= pinDrv_nxt;
    end
  end
  assign timerExtClkPinOe = pinDrv_r.drive;
  assign timerExtClkPinOut = pinDrv_r.level;

  // ------------------------------------------------------------
  // watchdog tick, divided only while it owns the prescaler
  // ------------------------------------------------------------
  logic wdTickOut_r;
  wire wdTickNxt = toWatchdog ? prescRise : watchdogTick;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wdTickOut_r <= 1'b0;
    end else begin
      wdTickOut_r <= wdTickNxt;
    end
  end
  assign watchdogTickOut = wdTickOut_r;

endmodule : tmz_timer

// [core/tmz_pkg.sv]
/*
  tmz_pkg: constants, register offsets, field positions and carrier types
  for the shared-prescaler timer/counter.
  Assumes one clock at 125 MHz; four clocks make one instruction cycle.
*/
package tmz_pkg;

  // ------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_OPTION = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_CMPCTRL = 3'h7;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_OPTION = 8'hFF;
  localparam logic [DATA_W-1:0] RST_COUNT = 8'h00;
  localparam logic [DATA_W-1:0] RST_CMPCTRL = 8'hFF;
  localparam logic [DATA_W-1:0] RST_PRESC = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int OPT_SRC_SEL = 5;
  localparam int OPT_EDGE_SEL = 4;
  localparam int OPT_ASSIGN = 3;
  localparam int OPT_RATIO_LO = 0;
  localparam int RATIO_W = 3;
  localparam int CMP_PIN_OUT_DIS = 6;
  localparam int CMP_SRC_N = 4;

  // ------------------------------------------------------------
  // phase timing: four clocks per instruction cycle
  // ------------------------------------------------------------
  localparam int PHASE_W = 2;
  localparam logic [PHASE_W-1:0] PH_Q1 = 2'h0;
  localparam logic [PHASE_W-1:0] PH_Q2 = 2'h1;
  localparam logic [PHASE_W-1:0] PH_Q4 = 2'h3;
  localparam int INHIBIT_W = 2;
  localparam logic [INHIBIT_W-1:0] INHIBIT_CYCLES = 2'h2;
  localparam logic [INHIBIT_W-1:0] INHIBIT_STEP = 2'h1;
  localparam logic [INHIBIT_W-1:0] INHIBIT_NONE = 2'h0;
  localparam logic [DATA_W-1:0] COUNT_STEP = 8'h01;

  // ------------------------------------------------------------
  // carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } tmz_bus_req_t;

  typedef struct packed {
    logic drive;
    logic level;
  } tmz_pin_drv_t;

endpackage : tmz_pkg

// [core/tmz_sync2.sv]
/*
  tmz_sync2: two flip-flop synchroniser, one stage pair per bit.
  Assumes inputs arrive from outside the mclk domain.
*/
`timescale 1ns/100ps
module tmz_sync2 #(
  parameter int WIDTH = 2
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  // ------------------------------------------------------------
  // per bit stage pair
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      logic meta_r;
      logic stable_r;
      // first stage feeds only the second
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          meta_r <= 1'b0;
          stable_r <= 1'b0;
        end else begin
          meta_r <= asyncIn[gi];
          stable_r <= meta_r;
        end
      end
      assign syncOut[gi] = stable_r;
    end
  endgenerate

endmodule : tmz_sync2

// [core/tmz_prescaler.sv]
/*
  tmz_prescaler: the shared 8-bit dividing counter, hidden from software.
  Assumes count enable and clear are one-cycle pulses on mclk.
*/
`timescale 1ns/100ps
module tmz_prescaler
  import tmz_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic countEn,
  input wire logic clear,
  input wire logic [RATIO_W-1:0] ratio,
  output logic tapLevel,
  output logic tapRise
);

  logic [DATA_W-1:0] cnt_r;
  logic [DATA_W-1:0] cnt_nxt;
  wire [DATA_W-1:0] cntInc = cnt_r + COUNT_STEP;

  // tap bit ratio: 000 taps bit 0 for 1:2, 111 taps bit 7 for 1:256
  assign tapLevel = cnt_r[ratio];
  assign tapRise = countEn & ~clear & ~cnt_r[ratio] & cntInc[ratio];

  // clear wins over a count in the same cycle
  assign cnt_nxt = clear ? RST_PRESC : (countEn ? cntInc : cnt_r);

  // counter register, zeros on every reset
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= RST_PRESC;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule : tmz_prescaler

// [verification/tmz_timer_sva.sv]
/*
  tmz_timer_sva: port-level checks on the timer/counter.
  Assumes one clock, mclk, and async active-low reset_n.
*/
`timescale 1ns/100ps
module tmz_timer_sva
  import tmz_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [DATA_W-1:0] regRdata,
  input wire logic timerExtClkPinIn,
  input wire logic timerExtClkPinOut,
  input wire logic timerExtClkPinOe,
  input wire logic comparatorOut,
  input wire logic gpioPinLevel,
  input wire logic gpioPinDrive,
  input wire logic watchdogTick,
  input wire logic watchdogClearInstr,
  input wire logic watchdogTickOut,
  input wire logic [DATA_W-1:0] timerCount
);
  // ------------------------------------------------------------
  // option shadow, settled once no option write for 15 cycles
  // ------------------------------------------------------------
  logic [DATA_W-1:0] optShadow_r;
  logic [3:0] optAge_r;
  wire optWr = regWr && (regAddr == OFS_OPTION);
  wire cntWr = regWr && (regAddr == OFS_COUNT);
  wire settled = (optAge_r == 4'hF);
  wire freeRun = settled && !optShadow_r[OPT_SRC_SEL] && optShadow_r[OPT_ASSIGN];
  wire halfRun = settled && (optShadow_r[5:0] == 6'h00);
  wire badAddr = (regAddr != OFS_OPTION) && (regAddr != OFS_COUNT)
    && (regAddr != OFS_CMPCTRL);

  // shadow tracks software option writes
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      optShadow_r <= RST_OPTION;
      optAge_r <= 4'h0;
    end else if (optWr) begin
      optShadow_r <= regWdata;
      optAge_r <= 4'h0;
    end else if (!settled) begin
      optAge_r <= optAge_r + 4'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_count_load: assert property (cntWr |=> timerCount == $past(regWdata))
    else $error("count write not loaded");
  a_write_inhibit: assert property (cntWr |=> ##1 $stable(timerCount) [*6])
    else $error("count moved right after a write");
  a_step_one: assert property ($changed(timerCount) && !$past(regWr)
    |-> timerCount == $past(timerCount) + COUNT_STEP)
    else $error("count stepped by other than one");
  a_free_period: assert property (freeRun && $changed(timerCount)
    && !$past(regWr) && !regWr ##1 (!regWr && freeRun) [*4]
    |-> $changed(timerCount) && $past(timerCount) == $past(timerCount, 3))
    else $error("free run period is not four clocks");
  a_half_period: assert property (halfRun && $changed(timerCount)
    && !$past(regWr) && !regWr ##1 (!regWr && halfRun) [*8]
    |-> $changed(timerCount) && $past(timerCount) == $past(timerCount, 7))
    else $error("divide by two period is not eight clocks");
  a_read_count: assert property (regRd && regAddr == OFS_COUNT
    |=> regRdata == $past(timerCount))
    else $error("count read back wrong");
  a_read_zero: assert property ((!regRd || badAddr) |=> regRdata == READ_ZERO)
    else $error("read data not zero");
  a_wdt_pass: assert property (settled && !optShadow_r[OPT_ASSIGN]
    |-> watchdogTickOut == $past(watchdogTick))
    else $error("watchdog tick not passed undivided");
  a_pin_gpio: assert property (settled && !optShadow_r[OPT_SRC_SEL]
    |-> timerExtClkPinOe == $past(gpioPinDrive)
    && timerExtClkPinOut == $past(gpioPinLevel))
    else $error("pin not handed to port logic");
endmodule : tmz_timer_sva

// [verification/tmz_edge_src.sv]
/*
  tmz_edge_src: far side model, an external clock source on the pin
  and the comparator output, both sent as bursts of pulses.
  Assumes the bench calls burst; both lines rest low between bursts.
*/
`timescale 1ns/100ps
module tmz_edge_src (
  output logic extPin,
  output logic cmpLvl
);
  initial begin
    extPin = 1'b0;
    cmpLvl = 1'b0;
  end

  // pulses with high and low time of half each, unrelated to mclk
  task automatic burst(input int nPin, input int nCmp, input realtime half);
    for (int i = 0; i < nPin; i++) begin
      #(half) extPin = 1'b1;
      #(half) extPin = 1'b0;
    end
    for (int i = 0; i < nCmp; i++) begin
      #(half) cmpLvl = 1'b1;
      #(half) cmpLvl = 1'b0;
    end
  endtask : burst
endmodule : tmz_edge_src

// [verification/tb_top.sv]
/*
  tb_top: self-checking bench for tmz_timer with edge source model.
  Assumes tmz_pkg, tmz_timer, tmz_timer_sva and tmz_edge_src compiled.
*/
`timescale 1ns/100ps
module tb_top
  import tmz_pkg::*;
;
  typedef struct packed {
    logic [7:0] opt;
    logic [7:0] cmp;
    logic [3:0] nPin;
    logic [3:0] nCmp;
    logic [7:0] cnt;
    logic oe;
  } tmz_row_t;

  logic mclk;
  logic reset_n = 1'b0;
  tmz_bus_req_t req = '0;
  logic [DATA_W-1:0] regRdata, timerCount, got;
  logic pinOut, pinOe, cmpLvl, extPin, wdtOut;
  logic gpioLevel = 1'b0;
  logic gpioDrive = 1'b0;
  logic wdtTick = 1'b0;
  logic wdtClear = 1'b0;
  int errTotal = 0;
  int samplesChecked = 0;
  int wdtSeen = 0;
  int base, n1, n2;
  wire pinWire = pinOe ? pinOut : extPin; // pin wire resolution
  tmz_row_t rows [7] = '{
    '{8'h38, 8'h50, 4'h5, 4'h3, 8'h05, 1'b0},
    '{8'h28, 8'h50, 4'h4, 4'h2, 8'h04, 1'b0},
    '{8'h28, 8'h40, 4'h4, 4'h6, 8'h06, 1'b0},
    '{8'h28, 8'h00, 4'h3, 4'h5, 8'h05, 1'b0},
    '{8'h20, 8'h40, 4'h0, 4'h6, 8'h03, 1'b0},
    '{8'h21, 8'h40, 4'h0, 4'h9, 8'h02, 1'b0},
    '{8'h28, 8'h10, 4'h0, 4'h4, 8'h04, 1'b1}
  };

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  tmz_edge_src src_u (.extPin(extPin), .cmpLvl(cmpLvl));

  tmz_timer dut_u (.mclk(mclk), .reset_n(reset_n), .regAddr(req.addr),
    .regWdata(req.wdata), .regWr(req.wr), .regRd(req.rd),
    .regRdata(regRdata), .timerExtClkPinIn(pinWire),
    .timerExtClkPinOut(pinOut), .timerExtClkPinOe(pinOe),
    .comparatorOut(cmpLvl), .gpioPinLevel(gpioLevel),
    .gpioPinDrive(gpioDrive), .watchdogTick(wdtTick),
    .watchdogClearInstr(wdtClear), .watchdogTickOut(wdtOut),
    .timerCount(timerCount));

  // count watchdog output pulses
  always @(posedge mclk) begin
    if (wdtOut === 1'b1) wdtSeen <= wdtSeen + 1;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errTotal++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge mclk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge mclk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 d = regRdata;
  endtask : rd

  // one-cycle pulse on a watchdog input, then settle
  task automatic wdt_pulse(input logic isClear);
    @(posedge mclk);
    if (isClear) wdtClear <= 1'b1;
    else wdtTick <= 1'b1;
    @(posedge mclk);
    wdtClear <= 1'b0;
    wdtTick <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : wdt_pulse

  // cycles until the count moves, bounded
  task automatic wait_change(output int n);
    logic [7:0] old;
    #1 old = timerCount;
    n = 0;
    while (timerCount === old && n < 100) begin
      @(posedge mclk);
      #1 n++;
    end
  endtask : wait_change

  task automatic reset_check();
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    #1 chk(timerCount, RST_COUNT);
    chk({7'h00, pinOe}, 8'h00);
    rd(OFS_OPTION, got);
    chk(got, RST_OPTION);
    rd(OFS_CMPCTRL, got);
    chk(got, RST_CMPCTRL);
    rd(3'h3, got);
    chk(got, READ_ZERO);
    chk(timerCount, RST_COUNT);
    $display("test reset done");
  endtask : reset_check

  task automatic results();
    $display("checked %0d, mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    reset_check();
    for (int i = 0; i < 7; i++) begin
      wdt_pulse(1'b1);
      wr(OFS_COUNT, 8'h00);
      if (rows[i].opt[OPT_ASSIGN]) begin
        wr(OFS_OPTION, 8'h0F);
        wdt_pulse(1'b1);
      end
      wr(OFS_CMPCTRL, rows[i].cmp);
      wr(OFS_OPTION, rows[i].opt);
      wr(OFS_COUNT, 8'h00);
      repeat (10) @(posedge mclk);
      src_u.burst(rows[i].nPin, rows[i].nCmp, i[0] ? 45.1 : 20.7);
      repeat (20) @(posedge mclk);
      rd(OFS_COUNT, got);
      chk(got, rows[i].cnt);
      chk({7'h00, pinOe}, {7'h00, rows[i].oe});
      $display("test row %0d done", i);
    end
    reset_check();
    // free run from near wrap, inhibit after the write
    wr(OFS_OPTION, 8'h08);
    wr(OFS_COUNT, 8'hFE);
    wait_change(n1);
    chk({7'h00, n1 >= 8}, 8'h01);
    chk(timerCount, 8'hFF);
    wait_change(n2);
    chk(timerCount, 8'h00);
    chk(n2[7:0], 8'h04);
    $display("test free run done");
    // count writes keep clearing a 1:16 prescaler
    wdt_pulse(1'b1);
    wr(OFS_OPTION, 8'h03);
    repeat (3) begin
      wr(OFS_COUNT, 8'h00);
      repeat (20) @(posedge mclk);
    end
    #1 chk(timerCount, 8'h00);
    // cleared prescaler: first step on the eighth cycle end after the write
    wait_change(n1);
    chk({7'h00, n1 >= 9 && n1 <= 12}, 8'h01);
    $display("test prescaler clear done");
    // watchdog owns prescaler at 1:2, clear restarts it
    wdt_pulse(1'b1);
    wr(OFS_COUNT, 8'h00);
    wr(OFS_OPTION, 8'h0F);
    wdt_pulse(1'b1);
    wr(OFS_OPTION, 8'h08);
    wdt_pulse(1'b1);
    base = wdtSeen;
    wdt_pulse(1'b0);
    wdt_pulse(1'b1);
    wdt_pulse(1'b0);
    wdt_pulse(1'b0);
    wdt_pulse(1'b0);
    chk(8'(wdtSeen - base), 8'h03);
    $display("test watchdog clear done");
    // timer owns prescaler: watchdog undivided, pin to port logic
    wdt_pulse(1'b1);
    wr(OFS_OPTION, 8'h00);
    gpioDrive <= 1'b1;
    gpioLevel <= 1'b1;
    base = wdtSeen;
    repeat (3) wdt_pulse(1'b0);
    repeat (30) @(posedge mclk);
    chk(8'(wdtSeen - base), 8'h03);
    #1 chk({6'h00, pinOe, pinOut}, 8'h03);
    $display("test undivided watchdog done");
    results();
  end

  // hang guard
  initial begin
    #100000;
    errTotal++;
    results();
  end
endmodule : tb_top

bind tmz_timer tmz_timer_sva chk_u (.mclk(mclk), .reset_n(reset_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .timerExtClkPinIn(timerExtClkPinIn),
  .timerExtClkPinOut(timerExtClkPinOut),
  .timerExtClkPinOe(timerExtClkPinOe), .comparatorOut(comparatorOut),
  .gpioPinLevel(gpioPinLevel), .gpioPinDrive(gpioPinDrive),
  .watchdogTick(watchdogTick), .watchdogClearInstr(watchdogClearInstr),
  .watchdogTickOut(watchdogTickOut), .timerCount(timerCount));
